// ### core/daqseq_top.sv
// data acquisition sequencer: timebase, mode control, sample store and wishbone registers
//
// How it works
// - streaming keeps only latest sample set; unfetched points are overwritten and lost
// - streaming sampling starts only after the start command is fully taken
// - each streaming point carries measured interval since previous sample
// - streaming runs until stop or reset command
// - buffered sampling paced by interval timer, not by host traffic
// - buffered start waits for trigger input when trigger enabled
// - buffered samples stored until count reached; returned only on get
// - early get is held and sending starts right after last sample
// - monitor register shows newest point without disturbing acquisition
// - burst samples one analog input; operation modes 5 to 7 refused
// - any command during burst aborts it and sets error flag
// - streaming get returns active channels in order, then delta time
// - buffered get returns channel lists in ascending order from the start list, then time list
// - streaming accepts only analog inputs and channels 11 and 12
// - interval spans 16000 s down to 2e-5 s single analog
// - two analog inputs need interval of at least 2e-4 s
// - outside burst, interval counted in 100 us ticks
// - burst interval counted in 400 ns ticks
// - single-point command reads one channel outside acquisition, no time
// - select register chooses channel list the following buffered retrieval starts from
// - checksum word appended in binary mode, omitted in ascii mode
// - sample count of all ones selects streaming mode
// - buffered count must be 1 to 12000
`timescale 1ns/100ps
module daqseq_top #(
  parameter int DEPTH = 12000,
  parameter int NORMAL_TICK = daqseq_pkg::NORMAL_TICK_CYC,
  parameter int BURST_TICK = daqseq_pkg::BURST_TICK_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [95:0] SAMPLE_IN,
  input wire logic TRIG_IN,
  output logic SAMPLE_STB,
  output logic BUSY
);

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // a request counts once: the cycle in which ack stands is not a second access
  wire bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wr = bus_req && WB_WE_I && WB_SEL_I[0];
  wire rd = bus_req && !WB_WE_I;
  wire wr_ctrl = wr && WB_ADR_I == daqseq_pkg::ADDR_CTRL;
  wire wr_chan = wr && WB_ADR_I == daqseq_pkg::ADDR_CHAN;
  wire wr_int = wr && WB_ADR_I == daqseq_pkg::ADDR_INTERVAL;
  wire wr_cnt = wr && WB_ADR_I == daqseq_pkg::ADDR_COUNT;
  wire wr_cmd = wr && WB_ADR_I == daqseq_pkg::ADDR_CMD;
  wire wr_sel = wr && WB_ADR_I == daqseq_pkg::ADDR_SELECT;
  wire rd_data = rd && WB_ADR_I == daqseq_pkg::ADDR_DATA;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  daqseq_pkg::daqseq_ctrl_s ctrl_q;
  logic [5:0] chan_q;
  logic [2:0] opmode_q;
  logic [27:0] interval_q;
  logic [13:0] count_q;
  logic [2:0] select_q;
  daqseq_pkg::daqseq_cmd_s cmd;
  // command code in the low nibble, single-point channel in the three bits above it
  assign cmd = '{cmd: WB_DAT_I[3:0], sel_ch: WB_DAT_I[6:4]};

  // software-written settings; select steers the next retrieval
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= '0;
      chan_q <= '0;
      opmode_q <= '0;
      interval_q <= daqseq_pkg::MIN_NORMAL_TICKS;
      count_q <= '0;
      select_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= daqseq_pkg::daqseq_ctrl_s'(WB_DAT_I[2:0]);
      if (wr_chan) chan_q <= WB_DAT_I[5:0];
      if (wr_chan) opmode_q <= WB_DAT_I[10:8];
      if (wr_int) interval_q <= WB_DAT_I[27:0];
      if (wr_cnt) count_q <= WB_DAT_I[13:0];
      if (wr_sel) select_q <= WB_DAT_I[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // setup legality
  // ----------------------------------------------------------------------
  logic [2:0] analog_n;
  // number of analog inputs decides the burst and dual-input limits
  always_comb begin
    analog_n = '0;
    for (int i = 0; i < daqseq_pkg::NUM_ANALOG; i++) analog_n = analog_n + 3'(chan_q[i]);
  end
  wire is_stream = count_q == daqseq_pkg::STREAM_COUNT;
  wire count_ok = is_stream || (count_q != '0 && count_q <= daqseq_pkg::MAX_COUNT);
  wire chan_ok = (chan_q & ~daqseq_pkg::STREAM_CH_MASK) == '0 && chan_q != '0;
  wire burst_ok = !ctrl_q.burst_mode || (analog_n == 3'h1 && (chan_q & ~daqseq_pkg::ANALOG_MASK) == '0
                  && opmode_q < daqseq_pkg::OPMODE_REFUSE_LO && !is_stream);
  wire int_ok = interval_q <= daqseq_pkg::MAX_INTERVAL_TICKS
                && (ctrl_q.burst_mode ? interval_q >= daqseq_pkg::MIN_BURST_TICKS
                    : interval_q >= (analog_n > 3'h1 ? daqseq_pkg::MIN_DUAL_TICKS
                                                     : daqseq_pkg::MIN_NORMAL_TICKS));
  // a refused start leaves the sequencer in idle or done and only raises the error flag
  wire setup_ok = count_ok && chan_ok && burst_ok && int_ok;

  // ----------------------------------------------------------------------
  // tick divider: 100 us normally, 400 ns in burst
  // ----------------------------------------------------------------------
  logic [15:0] div_q;
  wire [15:0] div_load = ctrl_q.burst_mode ? 16'(BURST_TICK - 1) : 16'(NORMAL_TICK - 1);
  wire tick = div_q == '0;
  logic [27:0] tcnt_q;
  logic [27:0] delta_q;
  logic [27:0] elapsed_q;
  daqseq_pkg::daqseq_state_e st_q;
  wire running = st_q == daqseq_pkg::ST_STREAM || st_q == daqseq_pkg::ST_BUFFER;
  wire sample = running && tick && tcnt_q == 28'h1;

  // the counters hold while idle, so the first sample lands one full interval after start
  // divider reloads at zero and while idle; interval down-counter reloads at terminal count
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= '0;
      tcnt_q <= '0;
      elapsed_q <= '0;
    end else begin
      div_q <= (tick || !running) ? div_load : div_q - 16'h1;
      if (!running) tcnt_q <= interval_q;
      else if (tick) tcnt_q <= (tcnt_q == 28'h1) ? interval_q : tcnt_q - 28'h1;
      if (!running || sample) elapsed_q <= '0;
      else if (tick) elapsed_q <= elapsed_q + 28'h1;
    end
  end

  // ----------------------------------------------------------------------
  // sample store: latest set for streaming, per-channel lists for buffered
  // ----------------------------------------------------------------------
  localparam int NUM_MEM = DEPTH * daqseq_pkg::NUM_CH;
  logic [15:0] mem [NUM_MEM];
  logic [15:0] latest_q [daqseq_pkg::NUM_CH];
  logic [13:0] wcount_q;
  logic done_q;
  logic get_pend_q;
  logic err_q;

  // latest set per channel, always overwritten
  genvar g;
  generate
    for (g = 0; g < daqseq_pkg::NUM_CH; g++) begin : g_ch
      always_ff @(posedge SYS_CLK) begin
        if (sample) latest_q[g] <= SAMPLE_IN[g*16 +: 16];
      end
    end
  endgenerate

  // one process owns the list store: a computed index makes the whole array its target
  always_ff @(posedge SYS_CLK) begin
    if (sample && st_q == daqseq_pkg::ST_BUFFER) begin
      for (int c = 0; c < daqseq_pkg::NUM_CH; c++) mem[c*DEPTH + int'(wcount_q)] <= SAMPLE_IN[c*16 +: 16];
    end
  end

  // ----------------------------------------------------------------------
  // readout walker: channel lists then time list, checksum last
  // ----------------------------------------------------------------------
  logic [2:0] rch_q;
  logic [13:0] ridx_q;
  logic [15:0] csum_q;
  logic cs_phase_q;
  wire stream_rd = st_q == daqseq_pkg::ST_STREAM;
  wire [2:0] last_ch = 3'(daqseq_pkg::NUM_CH);
  wire [15:0] time_word = stream_rd ? delta_q[15:0] : 16'(interval_q);
  wire [15:0] cur_word = rch_q == last_ch ? time_word
                         : stream_rd ? latest_q[rch_q] : mem[int'(rch_q)*DEPTH + int'(ridx_q)];
  // a streaming record holds one word per channel, so every list ends at once
  wire list_end = stream_rd || ridx_q + 14'h1 >= wcount_q;
  logic [2:0] next_ch;
  // next active channel above the current one; none left means the time list
  always_comb begin
    next_ch = last_ch;
    for (int i = daqseq_pkg::NUM_CH - 1; i >= 0; i--) if (chan_q[i] && 3'(i) > rch_q) next_ch = 3'(i);
  end
  wire rec_end = rch_q == last_ch && list_end;
  wire sending = st_q == daqseq_pkg::ST_SEND || (stream_rd && get_pend_q);
  logic [2:0] first_ch;
  // lowest active channel opens a record unless select names an active channel for a buffered get
  always_comb begin
    first_ch = last_ch;
    for (int i = daqseq_pkg::NUM_CH - 1; i >= 0; i--) if (chan_q[i]) first_ch = 3'(i);
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  wire is_get = wr_cmd && cmd.cmd == daqseq_pkg::CMD_GET;
  wire is_stop = wr_cmd && (cmd.cmd == daqseq_pkg::CMD_STOP || cmd.cmd == daqseq_pkg::CMD_RESET);
  // burst keeps the link shut: any command written while it runs ends it with an error
  wire burst_abort = wr_cmd && ctrl_q.burst_mode && running;
  wire buf_full = sample && wcount_q + 14'h1 == count_q;
  logic [15:0] single_q;

  // mode control; start takes effect on the cycle after the command write
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= daqseq_pkg::ST_IDLE;
      wcount_q <= '0;
      done_q <= 1'b0;
      get_pend_q <= 1'b0;
      err_q <= 1'b0;
      delta_q <= '0;
      rch_q <= '0;
      ridx_q <= '0;
      csum_q <= '0;
      cs_phase_q <= 1'b0;
      single_q <= '0;
    end else begin
      if (sample) delta_q <= elapsed_q + 28'h1;
      if (sample && st_q == daqseq_pkg::ST_BUFFER) wcount_q <= wcount_q + 14'h1;
      if (wr_cmd && cmd.cmd == daqseq_pkg::CMD_START) err_q <= 1'b0;
      if (is_get && !burst_abort) get_pend_q <= 1'b1;
      if (wr_cmd && cmd.cmd == daqseq_pkg::CMD_SINGLE && !running)
        single_q <= SAMPLE_IN[int'(cmd.sel_ch)*16 +: 16];
      unique case (st_q)
        daqseq_pkg::ST_IDLE, daqseq_pkg::ST_DONE: begin
          if (wr_cmd && cmd.cmd == daqseq_pkg::CMD_START) begin
            if (setup_ok) begin
              st_q <= is_stream ? daqseq_pkg::ST_STREAM : daqseq_pkg::ST_ARM;
              wcount_q <= '0;
              done_q <= 1'b0;
              get_pend_q <= 1'b0;
            end else begin
              err_q <= 1'b1;
            end
          end else if (st_q == daqseq_pkg::ST_DONE && get_pend_q) begin
            st_q <= daqseq_pkg::ST_SEND;
            rch_q <= chan_q[select_q] && select_q < last_ch ? select_q : first_ch;
            ridx_q <= '0;
            csum_q <= '0;
            cs_phase_q <= 1'b0;
          end
        end
        daqseq_pkg::ST_ARM: begin
          if (is_stop) st_q <= daqseq_pkg::ST_IDLE;
          else if (!ctrl_q.trig_enable || TRIG_IN) st_q <= daqseq_pkg::ST_BUFFER;
        end
        daqseq_pkg::ST_BUFFER: begin
          if (burst_abort) begin
            st_q <= daqseq_pkg::ST_IDLE;
            err_q <= 1'b1;
          end else if (is_stop) begin
            st_q <= daqseq_pkg::ST_IDLE;
          end else if (buf_full) begin
            st_q <= daqseq_pkg::ST_DONE;
            done_q <= 1'b1;
          end
        end
        daqseq_pkg::ST_STREAM: begin
          if (is_stop) begin
            st_q <= daqseq_pkg::ST_IDLE;
            get_pend_q <= 1'b0;
          end else if (is_get) begin
            rch_q <= first_ch;
            cs_phase_q <= 1'b0;
            csum_q <= '0;
          end
        end
        daqseq_pkg::ST_SEND: begin
          if (is_stop) st_q <= daqseq_pkg::ST_IDLE;
        end
        default: st_q <= daqseq_pkg::ST_IDLE;
      endcase
      // each data read during a get advances the walker
      if (rd_data && sending && !is_get) begin
        if (cs_phase_q || (rec_end && ctrl_q.ascii_mode)) begin
          get_pend_q <= 1'b0;
          cs_phase_q <= 1'b0;
          if (st_q == daqseq_pkg::ST_SEND) st_q <= daqseq_pkg::ST_DONE;
        end else begin
          csum_q <= csum_q + cur_word;
          if (rec_end) cs_phase_q <= 1'b1;
          else if (list_end) begin
            rch_q <= next_ch;
            ridx_q <= '0;
          end else ridx_q <= ridx_q + 14'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read mux and single-cycle ack
  // ----------------------------------------------------------------------
  // status bit 3 is spare so the state field keeps its own nibble
  wire [31:0] status_word = {23'h0, err_q, get_pend_q, done_q, sending, running, 1'b0, 3'(st_q)};
  wire [15:0] data_word = !sending ? 16'h0 : cs_phase_q ? csum_q : cur_word;
  wire [15:0] mon_word = latest_q[select_q < last_ch ? select_q : 3'h0];
  logic [31:0] rdata;
  always_comb begin
    unique case (WB_ADR_I)
      daqseq_pkg::ADDR_CTRL: rdata = {29'h0, ctrl_q};
      daqseq_pkg::ADDR_CHAN: rdata = {21'h0, opmode_q, 2'h0, chan_q};
      daqseq_pkg::ADDR_INTERVAL: rdata = {4'h0, interval_q};
      daqseq_pkg::ADDR_COUNT: rdata = {18'h0, count_q};
      daqseq_pkg::ADDR_STATUS: rdata = status_word;
      daqseq_pkg::ADDR_DATA: rdata = {16'h0, data_word};
      daqseq_pkg::ADDR_SELECT: rdata = {29'h0, select_q};
      daqseq_pkg::ADDR_MONITOR: rdata = {16'h0, running ? mon_word : single_q};
      default: rdata = 32'h0;
    endcase
  end

  // ack one cycle after request; unmapped reads return zero
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
      SAMPLE_STB <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= rdata;
      SAMPLE_STB <= sample;
      BUSY <= running;
    end
  end

endmodule

// ### core/daqseq_pkg.sv
// package: register map, field layouts, timing constants and types of the acquisition sequencer
package daqseq_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, word aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAN = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam logic [7:0] ADDR_SELECT = 8'h1c;
  localparam logic [7:0] ADDR_MONITOR = 8'h20;

  // ----------------------------------------------------------------------
  // command codes written to the command register
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_START = 4'h1;
  localparam logic [3:0] CMD_STOP = 4'h2;
  localparam logic [3:0] CMD_GET = 4'h3;
  localparam logic [3:0] CMD_SINGLE = 4'h4;
  localparam logic [3:0] CMD_RESET = 4'h5;

  // ----------------------------------------------------------------------
  // channel numbering: bits 0..3 analog inputs, bits 4..5 digital 11 and 12
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int NUM_ANALOG = 4;
  localparam logic [5:0] STREAM_CH_MASK = 6'h3f;
  localparam logic [5:0] ANALOG_MASK = 6'h0f;
  localparam logic [2:0] OPMODE_REFUSE_LO = 3'h5;

  // ----------------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int NORMAL_TICK_NS = 100000;
  localparam int BURST_TICK_NS = 400;
  localparam int NORMAL_TICK_CYC = NORMAL_TICK_NS * CLK_MHZ / 1000;
  localparam int BURST_TICK_CYC = BURST_TICK_NS * CLK_MHZ / 1000;
  // interval limits in ticks: 16000 s of 100 us, 2e-5 s of 400 ns, 2e-4 s of 100 us
  localparam logic [27:0] MAX_INTERVAL_TICKS = 28'h9896800;
  localparam logic [27:0] MIN_BURST_TICKS = 28'h0000032;
  localparam logic [27:0] MIN_DUAL_TICKS = 28'h0000002;
  localparam logic [27:0] MIN_NORMAL_TICKS = 28'h0000001;
  localparam logic [13:0] MAX_COUNT = 14'h2ee0;
  localparam logic [13:0] STREAM_COUNT = 14'h3fff;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STREAM = 3'b001,
    ST_ARM = 3'b010,
    ST_BUFFER = 3'b011,
    ST_DONE = 3'b100,
    ST_SEND = 3'b101
  } daqseq_state_e;

  typedef struct packed {
    logic [3:0] cmd;
    logic [2:0] sel_ch;
  } daqseq_cmd_s;

  typedef struct packed {
    logic ascii_mode;
    logic burst_mode;
    logic trig_enable;
  } daqseq_ctrl_s;

endpackage

// ### bench/daqseq_top_asserts.sv
// checker: port-level properties of the acquisition sequencer
`timescale 1ns/100ps
module daqseq_top_asserts #(
  parameter int NORMAL_TICK = daqseq_pkg::NORMAL_TICK_CYC,
  parameter int BURST_TICK = daqseq_pkg::BURST_TICK_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [95:0] SAMPLE_IN,
  input wire logic TRIG_IN,
  input wire logic SAMPLE_STB,
  input wire logic BUSY
);
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // ------
  // setup shadow
  // ------
  logic wr_ack, cmd_wr, start_wr, stop_wr, rst_wr, burst_q, seen_q;
  logic [27:0] intv_q;
  logic [13:0] cnt_q;
  logic [5:0] chan_q;
  logic [2:0] opm_q;
  logic [31:0] gap_q, exp_gap;
  // command decode on acknowledged writes only, as the slave sees them
  assign wr_ack = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I;
  assign cmd_wr = wr_ack && WB_ADR_I == daqseq_pkg::ADDR_CMD;
  assign start_wr = cmd_wr && WB_DAT_I[3:0] == daqseq_pkg::CMD_START;
  assign stop_wr = cmd_wr && WB_DAT_I[3:0] == daqseq_pkg::CMD_STOP;
  assign rst_wr = cmd_wr && WB_DAT_I[3:0] == daqseq_pkg::CMD_RESET;
  assign exp_gap = 32'(intv_q) * 32'(burst_q ? BURST_TICK : NORMAL_TICK);
  // shadow follows writes; the bench rewrites setup after every reset command
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      burst_q <= 1'b0;
      intv_q <= '0;
      cnt_q <= '0;
      chan_q <= '0;
      opm_q <= '0;
    end else if (wr_ack) begin
      if (WB_ADR_I == daqseq_pkg::ADDR_CTRL) burst_q <= WB_DAT_I[1];
      if (WB_ADR_I == daqseq_pkg::ADDR_INTERVAL) intv_q <= WB_DAT_I[27:0];
      if (WB_ADR_I == daqseq_pkg::ADDR_COUNT) cnt_q <= WB_DAT_I[13:0];
      if (WB_ADR_I == daqseq_pkg::ADDR_CHAN) chan_q <= WB_DAT_I[5:0];
      if (WB_ADR_I == daqseq_pkg::ADDR_CHAN) opm_q <= WB_DAT_I[10:8];
    end
  end
  // gap counter; only gaps inside one busy run are judged, the first sample waits on trigger
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= SAMPLE_STB ? 32'h1 : gap_q + 32'h1;
      seen_q <= BUSY && (seen_q || SAMPLE_STB);
    end
  end
  sequence quiet_s;
    !BUSY [*8];
  endsequence
  sequence rise_s;
    ##[1:8] BUSY;
  endsequence
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I > daqseq_pkg::ADDR_MONITOR |-> WB_DAT_O == 32'h0)
    else $error("unmapped read returned nonzero data");
  sample_gap_a: assert property (SAMPLE_STB && seen_q |-> gap_q == exp_gap)
    else $error("sample spacing differs from programmed interval");
  stop_idle_a: assert property (stop_wr |-> ##[1:8] !BUSY)
    else $error("stop command left acquisition running");
  reset_idle_a: assert property (rst_wr |-> ##[1:8] !BUSY)
    else $error("reset command left acquisition running");
  burst_abort_a: assert property (cmd_wr && burst_q && BUSY |-> ##[1:8] !BUSY)
    else $error("command during burst did not abort it");
  burst_refuse_a: assert property (start_wr && burst_q && opm_q >= daqseq_pkg::OPMODE_REFUSE_LO |=> quiet_s)
    else $error("burst started on a refused operation mode");
  stream_start_a: assert property (start_wr && !BUSY && !burst_q && cnt_q == daqseq_pkg::STREAM_COUNT
    && chan_q != 6'h0 && intv_q >= daqseq_pkg::MIN_DUAL_TICKS |-> rise_s)
    else $error("streaming start did not begin acquisition");
  reset_quiet_a: assert property ($rose(RST_N) |-> !BUSY && !WB_ACK_O && !SAMPLE_STB)
    else $error("outputs active right after reset");
endmodule
bind daqseq_top daqseq_top_asserts #(.NORMAL_TICK(NORMAL_TICK), .BURST_TICK(BURST_TICK)) u_asserts (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .SAMPLE_IN(SAMPLE_IN), .TRIG_IN(TRIG_IN), .SAMPLE_STB(SAMPLE_STB), .BUSY(BUSY)
);

// ### bench/daqseq_host_model.sv
// host model: classic wishbone master issuing setup writes, commands and reads
`timescale 1ns/100ps
module daqseq_host_model (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  // bus idle from time zero so nothing is requested during reset
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
  end
  // one cycle: raise after an edge, hold until ack is sampled, release at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule

// ### bench/daqseq_top_test.sv
// testbench: runs the sequencer through its modes against a queue model of the samples
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module daqseq_top_test;
  logic sys_clk, rst_n, cyc, stb, we, ack, trig, stb_out, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, sum;
  logic [95:0] samp;
  logic [95:0] rec[$];
  int failures, checks;
  logic [31:0] refuse_tab[4] = '{32'h504, 32'h604, 32'h704, 32'h003};
  // 250 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  daqseq_top #(.DEPTH(12000), .NORMAL_TICK(4), .BURST_TICK(2)) DUT (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SAMPLE_IN(samp), .TRIG_IN(trig),
    .SAMPLE_STB(stb_out), .BUSY(busy)
  );
  daqseq_host_model host (.clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .wdat(wdat));
  // sensor side: fresh values through reset, then each conversion held until strobed
  always @(posedge sys_clk) begin
    if (stb_out === 1'b1) rec.push_back(samp);
    if (rst_n !== 1'b1 || stb_out === 1'b1) samp <= {$urandom, $urandom, $urandom};
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    host.xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] ch, input logic [31:0] iv, input logic [31:0] n);
    wr(daqseq_pkg::ADDR_CTRL, c);
    wr(daqseq_pkg::ADDR_CHAN, ch);
    wr(daqseq_pkg::ADDR_INTERVAL, iv);
    wr(daqseq_pkg::ADDR_COUNT, n);
  endtask
  task automatic wait_stb(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      while (stb_out !== 1'b1) @(posedge sys_clk);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: whole sequence needs about 1300 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    trig = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(10));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // idle status, unmapped space ignores writes and reads zero
    rd(daqseq_pkg::ADDR_STATUS, q);
    `CHK(q, 32'h0)
    wr(8'h24, $urandom);
    rd(8'h24, q);
    `CHK(q, 32'h0)
    // single point of analog input index 2, no time attached
    wr(daqseq_pkg::ADDR_CHAN, 32'h3f);
    sum = {16'h0, samp[47:32]};
    wr(daqseq_pkg::ADDR_CMD, 32'h24);
    rd(daqseq_pkg::ADDR_MONITOR, q);
    `CHK(q[15:0], sum[15:0])
    `CHK(busy, 1'b0)
    // streaming on channels 11 and 12, ascii so no checksum; older points are overwritten
    setup(32'h4, 32'h30, 32'd50, 32'h3fff);
    wr(daqseq_pkg::ADDR_CMD, 32'h1);
    wait_stb(3);
    wr(daqseq_pkg::ADDR_CMD, 32'h3);
    rd(daqseq_pkg::ADDR_DATA, q);
    `CHK(q[15:0], rec[$][79:64])
    rd(daqseq_pkg::ADDR_DATA, q);
    `CHK(q[15:0], rec[$][95:80])
    rd(daqseq_pkg::ADDR_DATA, q);
    `CHK(q[15:0], 16'd50)
    `CHK(busy, 1'b1)
    wr(daqseq_pkg::ADDR_CMD, 32'h2);
    repeat (8) @(posedge sys_clk);
    `CHK(busy, 1'b0)
    // buffered, triggered, dual analog at minimum interval, get sent early
    rec.delete();
    setup(32'h1, 32'h3, 32'd2, 32'd4);
    wr(daqseq_pkg::ADDR_CMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    `CHK(rec.size(), 0)
    trig <= 1'b1;
    wr(daqseq_pkg::ADDR_CMD, 32'h3);
    rd(daqseq_pkg::ADDR_STATUS, q);
    `CHK(q[7], 1'b1)
    while (rec.size() < 4) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    trig <= 1'b0;
    `CHK(rec.size(), 4)
    `CHK(busy, 1'b0)
    sum = 32'h0;
    for (int i = 0; i < 12; i++) begin
      rd(daqseq_pkg::ADDR_DATA, q);
      sum = sum + {16'h0, q[15:0]};
      `CHK(q[15:0], (i < 8) ? rec[i % 4][(i / 4) * 16 +: 16] : 16'd2)
    end
    rd(daqseq_pkg::ADDR_DATA, q);
    `CHK(q[15:0], sum[15:0])
    // burst refuses modes 5 to 7 and more than one input
    foreach (refuse_tab[k]) begin
      setup(32'h2, refuse_tab[k], 32'd50, 32'd100);
      wr(daqseq_pkg::ADDR_CMD, 32'h1);
      rd(daqseq_pkg::ADDR_STATUS, q);
      `CHK({q[8], busy}, 2'b10)
      wr(daqseq_pkg::ADDR_CMD, 32'h5);
      rd(daqseq_pkg::ADDR_STATUS, q);
      `CHK(q[8], 1'b1) // error stays until the next start
    end
    // burst on one input; host writes select and reads the monitor, then a get aborts it on purpose
    setup(32'h2, 32'h4, 32'd50, 32'd1000);
    wr(daqseq_pkg::ADDR_CMD, 32'h1);
    wait_stb(3);
    wr(daqseq_pkg::ADDR_SELECT, 32'h2);
    rd(daqseq_pkg::ADDR_MONITOR, q);
    `CHK(q[15:0], rec[$][47:32])
    wr(daqseq_pkg::ADDR_CMD, 32'h3);
    repeat (8) @(posedge sys_clk);
    rd(daqseq_pkg::ADDR_STATUS, q);
    `CHK({q[8], busy}, 2'b10)
    finish_test();
  end
endmodule
